// ===== rtl/port_cfg_defines.vh
// constants for the port configuration subregister block
`ifndef PORT_CFG_DEFINES_VH
`define PORT_CFG_DEFINES_VH
`define SUB_NONE 8'h00
`define SUB_DIR 8'h01
`define SUB_ALT_EN 8'h02
`define SUB_DRAIN 8'h03
`define SUB_STRONG 8'h04
`define SUB_WAKE 8'h05
`define SUB_SET_LOW 8'h07
`define SUB_SET_HIGH 8'h08
`define RST_ADDR 8'h00
`define RST_ALT_ABC 8'h00
`define RST_ALT_D 8'h01
`define RST_ALT_SMALL_A 8'h04
`define RST_DRAIN_ABC 8'h00
`define RST_DRAIN_D 8'h01
`define RST_STRONG 8'h00
`define RST_WAKE 8'h00
`define RST_DIR 8'hff
`define RST_SET_LOW 8'h00
`define RST_SET_HIGH 8'h00
`define RST_SET_HIGH_SMALL_A 8'h04
`define PORT_KIND_ABC 2'h0
`define PORT_KIND_D 2'h1
`define PORT_KIND_SMALL_A 2'h2
`endif

// ===== rtl/port_pin_config_subregs.v
// per-port address and control registers with the configuration subregisters and pin steering
`timescale 1ns/100ps
`include "port_cfg_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// R1 - control register accesses go to the subregister named by the address register
// R2 - normal mode: direction 0 drives output data, 1 tristates and samples
// R3 - address 02h exposes the alternate-function enable subregister
// R4 - enable bit clear: pin is plain I/O following its direction bit
// R5 - enable bit set: alternate function owns the pin, direction ignored
// R6 - two function-set bits pick one of four alternate functions per pin
// R7 - enable resets 00h ports A-C, 01h port D, 04h small-package port A
// R8 - software must not enable pins without an alternate function
// R9 - address 03h exposes the output drain control subregister
// R10 - drain bit set kills high-side drive, giving open-drain output
// R11 - drain control applies whether or not the alternate function is on
// R12 - drain control resets 00h for ports A-C, 01h for port D
// R13 - address 04h exposes the high-drive enable subregister
// R14 - strong drive bit selects high current, also for alternate outputs
// R15 - address 05h exposes the wake source enable subregister
// R16 - while stopped, any edge on an enabled pin starts stop recovery
// R17 - high-drive and wake subregisters reset zero; bit n serves pin n
module port_pin_config_subregs #(
  parameter [1:0] PORT_KIND = `PORT_KIND_ABC
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // register access
  input wire addrWrite,
  input wire ctlWrite,
  input wire [7:0] writeData,
  output wire [7:0] addrReadData,
  output wire [7:0] ctlReadData,
  // port data and alternate functions
  input wire [7:0] outData,
  output reg [7:0] inData,
  input wire [31:0] altOut,
  input wire [31:0] altOutEn,
  output wire [7:0] funcSel0,
  output wire [7:0] funcSel1,
  // pins
  input wire [7:0] pinIn,
  output reg [7:0] pinOut,
  output reg [7:0] pinOe,
  output reg [7:0] pinStrong,
  // stop mode
  input wire stopMode,
  output reg wakeRequest
);

  // reset images depend on which port this instance stands for
  localparam [7:0] ALT_RST = (PORT_KIND == `PORT_KIND_D) ? `RST_ALT_D :
    (PORT_KIND == `PORT_KIND_SMALL_A) ? `RST_ALT_SMALL_A : `RST_ALT_ABC; // R7
  localparam [7:0] DRAIN_RST = (PORT_KIND == `PORT_KIND_D) ? `RST_DRAIN_D : `RST_DRAIN_ABC; // R12
  localparam [7:0] SET_HIGH_RST = (PORT_KIND == `PORT_KIND_SMALL_A) ? `RST_SET_HIGH_SMALL_A : `RST_SET_HIGH;

  reg [7:0] subAddr_q;
  reg [7:0] dir_q;
  reg [7:0] altEn_q;
  reg [7:0] drain_q;
  reg [7:0] strong_q;
  reg [7:0] wake_q;
  reg [7:0] setLow_q;
  reg [7:0] setHigh_q;
  reg [7:0] ctlRead_d;
  reg [7:0] pinMeta_q;
  reg [7:0] pinSync_q;
  reg [7:0] pinPrev_q;
  wire wrDir;
  wire wrAltEn;
  wire wrDrain;
  wire wrStrong;
  wire wrWake;
  wire wrSetLow;
  wire wrSetHigh;
  wire [7:0] edges;
  wire [7:0] pinLevel;
  wire [7:0] pinDrive;

  ////////////////////////////////////////////////////////////////////////////////
  // write strobes decoded from the address register
  // address 00h and unlisted codes raise no strobe, guarding against stray reconfiguration
  // a control write in the same edge as an address write still uses the old address
  assign wrDir = ctlWrite && (subAddr_q == `SUB_DIR); // R1 R2
  assign wrAltEn = ctlWrite && (subAddr_q == `SUB_ALT_EN); // R1 R3
  assign wrDrain = ctlWrite && (subAddr_q == `SUB_DRAIN); // R1 R9
  assign wrStrong = ctlWrite && (subAddr_q == `SUB_STRONG); // R1 R13
  assign wrWake = ctlWrite && (subAddr_q == `SUB_WAKE); // R1 R15
  assign wrSetLow = ctlWrite && (subAddr_q == `SUB_SET_LOW); // R1 R6
  assign wrSetHigh = ctlWrite && (subAddr_q == `SUB_SET_HIGH); // R1 R6

  ////////////////////////////////////////////////////////////////////////////////
  // address register
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      subAddr_q <= `RST_ADDR;
    end else if (addrWrite) begin
      subAddr_q <= writeData; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // subregister file, one flop group per subregister
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_q <= `RST_DIR;
    end else if (wrDir) begin
      dir_q <= writeData; // R2
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      altEn_q <= ALT_RST; // R7
    end else if (wrAltEn) begin
      altEn_q <= writeData; // R3
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drain_q <= DRAIN_RST; // R12
    end else if (wrDrain) begin
      drain_q <= writeData; // R9
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strong_q <= `RST_STRONG; // R17
    end else if (wrStrong) begin
      strong_q <= writeData; // R13
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= `RST_WAKE; // R17
    end else if (wrWake) begin
      wake_q <= writeData; // R15
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      setLow_q <= `RST_SET_LOW;
    end else if (wrSetLow) begin
      setLow_q <= writeData; // R6
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      setHigh_q <= SET_HIGH_RST;
    end else if (wrSetHigh) begin
      setHigh_q <= writeData; // R6
    end
  end

  always @* begin
    case (subAddr_q) // R1
      `SUB_DIR: ctlRead_d = dir_q;
      `SUB_ALT_EN: ctlRead_d = altEn_q; // R3
      `SUB_DRAIN: ctlRead_d = drain_q; // R9
      `SUB_STRONG: ctlRead_d = strong_q; // R13
      `SUB_WAKE: ctlRead_d = wake_q; // R15
      `SUB_SET_LOW: ctlRead_d = setLow_q;
      `SUB_SET_HIGH: ctlRead_d = setHigh_q;
      default: ctlRead_d = 8'h00;
    endcase
  end

  assign addrReadData = subAddr_q;
  assign ctlReadData = ctlRead_d;
  assign funcSel0 = setLow_q; // R6
  assign funcSel1 = setHigh_q; // R6

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser and wake detection
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_q <= 8'h00;
      pinSync_q <= 8'h00;
      pinPrev_q <= 8'h00;
      inData <= 8'h00;
      wakeRequest <= 1'b0;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
      inData <= pinSync_q; // R2
      wakeRequest <= stopMode && (|(edges & wake_q)); // R16
    end
  end

  assign edges = pinSync_q ^ pinPrev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin drive selection
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : pinGen
      wire [1:0] sel;
      assign sel = {setHigh_q[i], setLow_q[i]}; // R6
      // alternate source for pin i, function k sits at bit 8*k+i
      assign pinLevel[i] = altEn_q[i] ? altOut[8 * sel + i] : outData[i]; // R5 R4
      assign pinDrive[i] = altEn_q[i] ? altOutEn[8 * sel + i] : ~dir_q[i]; // R5 R4 R2
    end
  endgenerate

  // registered so pin outputs come from flip-flops; costs one cycle of latency
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut <= 8'h00;
      pinOe <= 8'h00;
      pinStrong <= 8'h00;
    end else begin
      pinOut <= pinLevel;
      // open drain: only a low level is driven, whatever owns the pin
      pinOe <= pinDrive & ~(drain_q & pinLevel); // R10 R11
      pinStrong <= strong_q; // R14 R17
    end
  end

endmodule // port_pin_config_subregs

// ===== bench/port_cfg_monitor.sv
// assertion checker for the port configuration block
`timescale 1ns/100ps
module port_cfg_monitor(
  input wire sys_clk, input wire reset_n,
  input wire addrWrite, input wire ctlWrite, input wire [7:0] writeData,
  input wire [7:0] addrReadData, input wire [7:0] ctlReadData,
  input wire [7:0] pinOut, input wire [7:0] pinOe, input wire [7:0] pinStrong,
  input wire stopMode, input wire wakeRequest
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_addr; addrWrite |=> addrReadData == $past(writeData); endproperty
  a_addr: assert property (p_addr) else $error("address readback wrong");
  property p_none; addrReadData == 8'h00 || addrReadData == 8'h06 || addrReadData > 8'h08 |-> ctlReadData == 8'h00;
  endproperty
  a_none: assert property (p_none) else $error("unused code reads nonzero");
  property p_alt; ctlWrite && !addrWrite && addrReadData == 8'h02 |=> ctlReadData == $past(writeData); endproperty
  a_alt: assert property (p_alt) else $error("enable write lost");
  property p_drn; ctlWrite && !addrWrite && addrReadData == 8'h03 |=> ctlReadData == $past(writeData); endproperty
  a_drn: assert property (p_drn) else $error("drain write lost");
  property p_str; ctlWrite && !addrWrite && addrReadData == 8'h04 |=> ctlReadData == $past(writeData); endproperty
  a_str: assert property (p_str) else $error("strong write lost");
  property p_wak; ctlWrite && !addrWrite && addrReadData == 8'h05 |=> ctlReadData == $past(writeData); endproperty
  a_wak: assert property (p_wak) else $error("wake write lost");
  // open drain must never drive a high level
  property p_od; ctlWrite && !addrWrite && addrReadData == 8'h03 && writeData == 8'hff |-> ##2 (pinOe & pinOut) == 8'h00;
  endproperty
  a_od: assert property (p_od) else $error("drain pin drives high");
  property p_pd; ctlWrite && !addrWrite && addrReadData == 8'h04 |-> ##2 pinStrong == $past(writeData, 2); endproperty
  a_pd: assert property (p_pd) else $error("strong drive not applied");
  property p_sl; !stopMode [*4] |=> !wakeRequest; endproperty
  a_sl: assert property (p_sl) else $error("wake while running");
endmodule // port_cfg_monitor
bind port_pin_config_subregs port_cfg_monitor u_port_cfg_monitor(.sys_clk, .reset_n, .addrWrite, .ctlWrite,
  .writeData, .addrReadData, .ctlReadData, .pinOut, .pinOe, .pinStrong, .stopMode, .wakeRequest);

// ===== bench/port_pin_config_subregs_tb.sv
// self-checking bench for the port configuration block
`timescale 1ns/100ps
module port_pin_config_subregs_tb;
  reg sys_clk = 1'b0, reset_n = 1'b0, addrWrite = 1'b0, ctlWrite = 1'b0, stopMode = 1'b0;
  reg [7:0] writeData = 8'h00, outData = 8'h00, pinIn = 8'h00;
  reg [31:0] altOut = 32'hc3963c69, altOutEn = 32'hffffffff;
  wire [7:0] addrReadData, ctlReadData, inData, funcSel0, funcSel1, pinOut, pinOe, pinStrong;
  wire wakeRequest;
  wire [7:0] ctlReadD, ctlReadSmallA;
  integer fail_count = 0, comparisons = 0, i, n;
  port_pin_config_subregs u_port_pin_config_subregs(.sys_clk, .reset_n, .addrWrite, .ctlWrite, .writeData,
    .addrReadData, .ctlReadData, .outData, .inData, .altOut, .altOutEn, .funcSel0, .funcSel1, .pinIn, .pinOut,
    .pinOe, .pinStrong, .stopMode, .wakeRequest);
  // extra instances only to see the per-port reset images; they share every input
  port_pin_config_subregs #(.PORT_KIND(2'h1)) u_port_pin_config_subregs_d(.sys_clk, .reset_n, .addrWrite,
    .ctlWrite, .writeData, .addrReadData(), .ctlReadData(ctlReadD), .outData, .inData(), .altOut, .altOutEn,
    .funcSel0(), .funcSel1(), .pinIn, .pinOut(), .pinOe(), .pinStrong(), .stopMode, .wakeRequest());
  port_pin_config_subregs #(.PORT_KIND(2'h2)) u_port_pin_config_subregs_small(.sys_clk, .reset_n, .addrWrite,
    .ctlWrite, .writeData, .addrReadData(), .ctlReadData(ctlReadSmallA), .outData, .inData(), .altOut, .altOutEn,
    .funcSel0(), .funcSel1(), .pinIn, .pinOut(), .pinOe(), .pinStrong(), .stopMode, .wakeRequest());
  initial forever #25 sys_clk = ~sys_clk;
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task sa(input [7:0] a);
    begin @(negedge sys_clk) addrWrite = 1'b1; writeData = a; @(negedge sys_clk) addrWrite = 1'b0; end
  endtask
  // extra edge so registered pin outputs have settled
  task wr(input [7:0] a, input [7:0] d);
    begin sa(a); ctlWrite = 1'b1; writeData = d; @(negedge sys_clk) ctlWrite = 1'b0; @(negedge sys_clk); end
  endtask
  task t_reset;
    begin
      for (i = 1; i < 10; i = i + 1) begin
        sa(i[7:0]);
        chk(ctlReadData, i == 1 ? 8'hff : 8'h00);
        chk(ctlReadD, i == 1 ? 8'hff : (i == 2 || i == 3) ? 8'h01 : 8'h00);
        chk(ctlReadSmallA, i == 1 ? 8'hff : (i == 2 || i == 8) ? 8'h04 : 8'h00);
      end
      chk(pinOe, 8'h00);
    end
  endtask
  task t_regs;
    for (i = 0; i < 10; i = i + 1) begin
      wr(i[7:0], 8'h5a ^ i[7:0]);
      chk(ctlReadData, (i == 0 || i == 6 || i == 9) ? 8'h00 : 8'h5a ^ i[7:0]);
    end
  endtask
  task t_pins;
    begin
      outData = 8'ha5; wr(2, 8'h00); wr(3, 8'h00); wr(1, 8'h00);
      chk(pinOut, 8'ha5);
      chk(pinOe, 8'hff);
      wr(1, 8'h0f); wr(3, 8'hff);
      chk(pinOe, 8'h50);
      // every pin has a source in altOut, so enabling all of them is allowed
      wr(3, 8'h00); wr(2, 8'hff);
      chk(pinOe, 8'hff);
      for (i = 0; i < 4; i = i + 1) begin
        wr(7, {8{i[0]}});
        wr(8, {8{i[1]}});
        chk(funcSel0, {8{i[0]}});
        chk(funcSel1, {8{i[1]}});
        chk(pinOut, altOut[8*i +: 8]);
      end
      wr(3, 8'hff);
      chk(pinOe, 8'h3c);
      wr(4, 8'h81);
      chk(pinStrong, 8'h81);
    end
  endtask
  task t_wake;
    begin
      wr(5, 8'h02); stopMode = 1'b1; pinIn = 8'h01;
      for (n = 0; n < 6; n = n + 1) @(negedge sys_clk) chk({7'h00, wakeRequest}, 8'h00);
      chk(inData, 8'h01);
      pinIn = 8'h03;
      for (n = 0; n < 6 && wakeRequest !== 1'b1; n = n + 1) @(negedge sys_clk);
      chk({7'h00, wakeRequest}, 8'h01);
      if (wakeRequest !== 1'b1) end_sim;
      @(negedge sys_clk) chk({7'h00, wakeRequest}, 8'h00);
      // an edge while running must not wake
      stopMode = 1'b0;
      pinIn = 8'h01;
      for (n = 0; n < 6; n = n + 1) @(negedge sys_clk) chk({7'h00, wakeRequest}, 8'h00);
    end
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset; t_regs; t_pins;
    // mid-run reset must bring back every reset image
    @(negedge sys_clk) reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset; t_wake;
    end_sim;
  end
endmodule // port_pin_config_subregs_tb
